// [core/crs_top.sv]
// clock divider, reset sequencing, strap capture, interrupt latch and powerdown exit
// assumes input_clock is sampled by the much faster system clock
`timescale 1ns/10ps
module crs_top
    import crs_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic input_clock,
    output logic crystal_drive_output,
    output logic output_timing_clock,
    input wire logic reset_input_n,
    output logic reset_output,
    output logic bus_abort,
    output logic fetch_start,
    output logic [19:0] fetch_address,
    input wire logic nmi_input,
    input wire logic nmi_ack,
    output logic nmi_pending,
    output logic [7:0] nmi_vector,
    input wire logic test_busy_n,
    input wire logic wait_exec,
    output logic cpu_stall,
    input wire logic [3:0] bus_phase,
    input wire logic bus_addr19,
    input wire logic bus_dma_cycle,
    input wire logic bus_refresh_cycle,
    input wire logic strap_in,
    output logic strap_out,
    output logic strap_oe,
    output logic strap_pullup_en,
    output logic in_circuit_test_mode,
    output logic pins_float,
    input wire logic powerdown_req,
    input wire logic powerdown_wake,
    input wire logic powerdown_delay_pin,
    output logic pd_pullup_en,
    output logic pd_active
);

    ////////////////////////////////////////////////////////////////////////////
    crs_sync_if #(.WIDTH(CRS_SYNC_WIDTH)) sync_bus ();

    assign sync_bus.raw = {powerdown_delay_pin, test_busy_n, nmi_input, reset_input_n};

    crs_sync #(.WIDTH(CRS_SYNC_WIDTH), .RESET_VAL(CRS_SYNC_RESET_VAL)) u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .port(sync_bus.sync)
    );

    wire in_reset = !sync_bus.synced[CRS_SYNC_RESET_BIT]; // see RQ13
    wire nmi_s = sync_bus.synced[CRS_SYNC_NMI_BIT];
    wire test_s = sync_bus.synced[CRS_SYNC_TEST_BIT];
    wire pd_s = sync_bus.synced[CRS_SYNC_PD_BIT];

    ////////////////////////////////////////////////////////////////////////////
    crs_state_t state_reg;
    crs_state_t state_next;
    logic icl_reg;
    logic output_timing_clock_reg;
    logic output_timing_clock_next;
    logic reset_output_reg;
    logic fetch_reg;
    logic nmi_q_reg;
    logic nmi_pend_reg;
    logic nmi_pend_next;
    logic strap_cap_reg;
    logic test_mode_reg;
    logic strap_out_reg;
    logic strap_oe_reg;
    logic xtal_reg;

    wire clk_fall = icl_reg && !input_clock;
    wire nmi_rise = nmi_s && !nmi_q_reg;
    wire leaving_reset = (state_reg == CRS_ST_RESET) && !in_reset;
    wire align_done = (state_reg == CRS_ST_ALIGN) && clk_fall && !output_timing_clock_reg;
    wire clk_frozen = (state_reg == CRS_ST_PWRDN) || (state_reg == CRS_ST_PD_WAIT);
    wire bus_drive = (state_reg == CRS_ST_RUN) && !test_mode_reg && |bus_phase[CRS_PHASE_T3:CRS_PHASE_T1];
    wire status_bit = bus_dma_cycle || bus_refresh_cycle; // see RQ8
    wire strap_next = bus_phase[CRS_PHASE_T1] ? bus_addr19 : status_bit; // see RQ7

    always_comb begin
        state_next = state_reg;
        if (in_reset) begin
            state_next = CRS_ST_RESET; // see RQ2
        end else begin
            case (state_reg)
                CRS_ST_RESET: state_next = CRS_ST_ALIGN;
                CRS_ST_ALIGN: if (align_done) state_next = CRS_ST_RUN; // see RQ4
                CRS_ST_RUN: if (powerdown_req) state_next = CRS_ST_PWRDN;
                CRS_ST_PWRDN: if (powerdown_wake) state_next = CRS_ST_PD_WAIT;
                CRS_ST_PD_WAIT: if (pd_s) state_next = CRS_ST_RUN; // see RQ10
                default: state_next = CRS_ST_RESET;
            endcase
        end
    end

    // clock held low in reset so the first fall after release sets a known phase
    assign output_timing_clock_next = (in_reset || state_reg == CRS_ST_RESET) ? CRS_OUTPUT_TIMING_CLOCK_RESET :
                         (clk_fall && !clk_frozen) ? !output_timing_clock_reg : output_timing_clock_reg; // see RQ1
    // set beats the acknowledge so an edge in the clearing cycle is kept
    assign nmi_pend_next = !in_reset && (nmi_rise || (nmi_pend_reg && !nmi_ack)); // see RQ5

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= CRS_ST_RESET;
            icl_reg <= 1'b0;
            output_timing_clock_reg <= CRS_OUTPUT_TIMING_CLOCK_RESET;
            reset_output_reg <= CRS_RESET_OUTPUT_RESET;
            fetch_reg <= 1'b0;
            nmi_q_reg <= 1'b0;
            nmi_pend_reg <= 1'b0;
            xtal_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            icl_reg <= input_clock;
            output_timing_clock_reg <= output_timing_clock_next;
            reset_output_reg <= in_reset; // see RQ3
            fetch_reg <= align_done && !in_reset; // see RQ4
            nmi_q_reg <= nmi_s;
            nmi_pend_reg <= nmi_pend_next;
            // oscillator stops in powerdown and restarts while the delay pin charges
            xtal_reg <= (state_reg != CRS_ST_PWRDN) && !input_clock;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap is sampled every reset cycle; the last sample before release counts
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            strap_cap_reg <= 1'b1;
            test_mode_reg <= 1'b0;
            strap_out_reg <= 1'b0;
            strap_oe_reg <= 1'b0;
        end else begin
            if (state_reg == CRS_ST_RESET) begin
                strap_cap_reg <= strap_in; // see RQ9
            end
            if (in_reset) begin
                test_mode_reg <= 1'b0;
            end else if (leaving_reset) begin
                test_mode_reg <= !strap_cap_reg; // see RQ9
            end
            strap_out_reg <= strap_next;
            strap_oe_reg <= bus_drive && !in_reset; // see RQ11
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign crystal_drive_output = xtal_reg;
    assign output_timing_clock = output_timing_clock_reg;
    assign reset_output = reset_output_reg;
    assign bus_abort = in_reset; // see RQ2
    assign fetch_start = fetch_reg;
    assign fetch_address = CRS_FETCH_ADDR;
    assign nmi_pending = nmi_pend_reg;
    assign nmi_vector = CRS_NMI_VECTOR;
    assign cpu_stall = wait_exec && test_s; // see RQ6
    assign strap_out = strap_out_reg;
    assign strap_oe = strap_oe_reg;
    assign strap_pullup_en = (state_reg == CRS_ST_RESET); // see RQ12
    assign in_circuit_test_mode = test_mode_reg;
    assign pins_float = test_mode_reg; // see RQ11
    assign pd_pullup_en = !in_reset;
    assign pd_active = clk_frozen;

    ////////////////////////////////////////////////////////////////////////////
    a_output_timing_clock_toggles: assert property (@(posedge clock) disable iff (!arst_n) // see RQ1
        (state_reg == CRS_ST_RUN && !in_reset && clk_fall) |=> output_timing_clock != $past(output_timing_clock))
        else $error("output clock missed an input falling edge");
    a_output_timing_clock_steady: assert property (@(posedge clock) disable iff (!arst_n) // see RQ1
        (!clk_fall && !in_reset && state_reg != CRS_ST_RESET) |=> $stable(output_timing_clock))
        else $error("output clock moved without an input falling edge");
    a_abort_reset: assert property (@(posedge clock) disable iff (!arst_n) // see RQ2
        $fell(reset_input_n) |-> ##[1:3] (bus_abort && state_next == CRS_ST_RESET))
        else $error("reset input did not abort the bus");
    a_reset_output_held: assert property (@(posedge clock) disable iff (!arst_n) // see RQ3
        in_reset ##1 in_reset |-> reset_output)
        else $error("reset output dropped while reset held");
    a_fetch_phase: assert property (@(posedge clock) disable iff (!arst_n) // see RQ4
        fetch_start |-> (output_timing_clock && fetch_address == CRS_FETCH_ADDR && $past(state_reg) == CRS_ST_ALIGN))
        else $error("fetch started without aligned clock");
    a_nmi_latched: assert property (@(posedge clock) disable iff (!arst_n) // see RQ5
        (nmi_rise && !in_reset) |=> (nmi_pending && nmi_vector == CRS_NMI_VECTOR))
        else $error("interrupt edge not latched");
    a_status_phase: assert property (@(posedge clock) disable iff (!arst_n) // see RQ8
        (bus_drive && !in_reset && bus_phase[CRS_PHASE_T2]) |=> (strap_oe && strap_out == $past(status_bit)))
        else $error("status bit wrong in T2");
    a_strap_input: assert property (@(posedge clock) disable iff (!arst_n) // see RQ9
        (state_reg == CRS_ST_RESET) |-> (!strap_oe && strap_pullup_en))
        else $error("strap pin driven or unpulled in reset");
    a_test_float: assert property (@(posedge clock) disable iff (!arst_n) // see RQ11
        (test_mode_reg && !in_reset) |=> (!strap_oe && pins_float))
        else $error("pins driven in test mode");
    a_pd_wait: assert property (@(posedge clock) disable iff (!arst_n) // see RQ10
        (state_reg == CRS_ST_PD_WAIT && !pd_s && !in_reset) |=> state_reg == CRS_ST_PD_WAIT)
        else $error("resumed before the delay pin rose");
    a_sync_delay: assert property (@(posedge clock) disable iff (!arst_n) // see RQ13
        $past(arst_n, 2) |-> sync_bus.synced == $past(sync_bus.raw, 2))
        else $error("synchroniser latency is not two cycles");
    a_addr_phase: assert property (@(posedge clock) disable iff (!arst_n) // see RQ7
        (bus_drive && !in_reset && bus_phase[CRS_PHASE_T1]) |=> (strap_oe && strap_out == $past(bus_addr19)))
        else $error("address bit wrong in T1");
    a_nmi_set_wins: assert property (@(posedge clock) disable iff (!arst_n) // see RQ5
        (nmi_rise && nmi_ack && !in_reset) |=> nmi_pending)
        else $error("acknowledge swallowed a new interrupt edge");
    // busy pin is seen two clocks late through the synchroniser
    a_stall_busy: assert property (@(posedge clock) disable iff (!arst_n) // see RQ6
        (wait_exec && $past(arst_n) && $past(arst_n, 2)) |-> cpu_stall == $past(test_busy_n, 2))
        else $error("stall does not follow the busy input");
    a_fetch_pulse: assert property (@(posedge clock) disable iff (!arst_n) // see RQ4
        fetch_start |=> !fetch_start)
        else $error("fetch start longer than one cycle");
    a_output_timing_clock_reset: assert property (@(posedge clock) disable iff (!arst_n) // see RQ4
        (state_reg == CRS_ST_RESET) |-> !output_timing_clock)
        else $error("output clock not parked low in reset");
    a_xtal_stopped: assert property (@(posedge clock) disable iff (!arst_n) // see RQ10
        ($past(state_reg) == CRS_ST_PWRDN) |-> !crystal_drive_output)
        else $error("crystal drive running in powerdown");
    // the strap level one clock before release decides the mode
    a_test_capture: assert property (@(posedge clock) disable iff (!arst_n) // see RQ9
        (leaving_reset && $past(state_reg) == CRS_ST_RESET) |=> in_circuit_test_mode == !$past(strap_in, 2))
        else $error("test mode does not follow the strap");

endmodule

// [core/crs_pkg.sv]
// constants, state type and pin-group layout for the clock, reset and strap control block
// assumes one 125 MHz system clock; asynchronous pins are brought into that clock through the two-flip-flop synchroniser
//
// What this block does
// RQ1: output clock is input clock halved, 50% duty, toggling on input falling edges.
// RQ2: reset input aborts any bus cycle at in_circuit_test_mode and forces known pin levels.
// RQ3: reset output stays asserted for as long as reset input is asserted.
// RQ4: on reset release, align output clock phase, then fetch from 0FFFF0H.
// RQ5: edge on non-maskable interrupt input is latched and requests vector type 2.
// RQ6: wait instruction stalls until coprocessor-wait input is sampled low.
// RQ7: top address pin carries address bit 19 in T1, status in T2 and T3.
// RQ8: bus master status is low for processor cycles, high for DMA or refresh.
// RQ9: top address pin is an input during reset; low there selects test mode.
// RQ10: after powerdown exit, wait for the delay pin before resuming normal operation.
// RQ11: in test mode every output floats except the crystal drive output.
// RQ12: during reset the strap pin is weakly pulled high.
// RQ13: asynchronous reset and interrupt inputs pass two synchroniser flip-flops first.
package crs_pkg;

    localparam logic [19:0] CRS_FETCH_ADDR = 20'hFFFF0;
    localparam logic [7:0] CRS_NMI_VECTOR = 8'h02;

    // synchroniser lanes and their values after reset
    localparam int CRS_SYNC_WIDTH = 4;
    localparam int CRS_SYNC_RESET_BIT = 0;
    localparam int CRS_SYNC_NMI_BIT = 1;
    localparam int CRS_SYNC_TEST_BIT = 2;
    localparam int CRS_SYNC_PD_BIT = 3;
    localparam logic [3:0] CRS_SYNC_RESET_VAL = 4'h4;

    // one-hot bus phase input layout
    localparam int CRS_PHASE_T1 = 0;
    localparam int CRS_PHASE_T2 = 1;
    localparam int CRS_PHASE_T3 = 2;
    localparam int CRS_PHASE_T4 = 3;

    localparam logic CRS_OUTPUT_TIMING_CLOCK_RESET = 1'b0;
    localparam logic CRS_RESET_OUTPUT_RESET = 1'b1;

    typedef enum logic [4:0] {
        CRS_ST_RESET = 5'b00001,
        CRS_ST_ALIGN = 5'b00010,
        CRS_ST_RUN = 5'b00100,
        CRS_ST_PWRDN = 5'b01000,
        CRS_ST_PD_WAIT = 5'b10000
    } crs_state_t;

endpackage

// [core/crs_sync_if.sv]
// raw and synchronised copies of the asynchronous input pins
// assumes both ends share the system clock
`timescale 1ns/10ps
interface crs_sync_if #(parameter int WIDTH = 4);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;
    modport src (output raw, input synced);
    modport sync (input raw, output synced);
endinterface

// [core/crs_sync.sv]
// two-flip-flop synchroniser, one lane per bit of the carrier
// assumes the carrier raw lanes are driven by the top module
`timescale 1ns/10ps
module crs_sync
    import crs_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clock,
    input wire logic arst_n,
    crs_sync_if.sync port
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_lane
            logic stage1_reg;
            logic stage2_reg;
            // stage1 feeds only stage2 to keep metastability away from logic
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    stage1_reg <= RESET_VAL[i];
                    stage2_reg <= RESET_VAL[i];
                end else begin
                    stage1_reg <= port.raw[i]; // see RQ13
                    stage2_reg <= stage1_reg;
                end
            end
            assign port.synced[i] = stage2_reg;
        end
    endgenerate
endmodule

// [testbench/crs_board.sv]
// board model: crystal oscillator, strap pull resistor, optional strap hold-low
// assumes the system clock runs well above the oscillator it makes
`timescale 1ns/10ps
module crs_board (
    input wire logic clock,
    input wire logic hold_low,
    input wire logic strap_out,
    input wire logic strap_oe,
    input wire logic strap_pullup_en,
    output logic input_clock,
    output logic strap_in
);
    logic [2:0] div_reg = 3'h0;
    logic last_reg = 1'b1;
    initial input_clock = 1'b0;
    // oscillator period is ten system clocks
    always @(posedge clock) begin
        div_reg <= (div_reg == 3'h4) ? 3'h0 : div_reg + 3'h1;
        if (div_reg == 3'h4) input_clock <= ~input_clock;
        if (strap_oe) last_reg <= strap_out;
    end
    // a released line without pull-up must not keep the last level, so it shows the inverse
    always @(*) begin
        if (strap_oe) strap_in = strap_out;
        else if (hold_low) strap_in = 1'b0;
        else if (strap_pullup_en) strap_in = 1'b1;
        else strap_in = ~last_reg;
    end
endmodule

// [testbench/clock_reset_strap_control_test.sv]
// self-checking bench for the clock, reset and strap control block
// assumes the board model supplies the oscillator and the strap pin level
`timescale 1ns/10ps
module clock_reset_strap_control_test import crs_pkg::*;;
    logic clock = 1'b0, arst_n = 1'b0, reset_input_n = 1'b0, nmi_input = 1'b0, nmi_ack = 1'b0;
    logic test_busy_n = 1'b1, wait_exec = 1'b0, bus_addr19 = 1'b0, bus_dma_cycle = 1'b0;
    logic bus_refresh_cycle = 1'b0, powerdown_req = 1'b0, powerdown_wake = 1'b0;
    logic powerdown_delay_pin = 1'b0, hold_low = 1'b0;
    logic [3:0] bus_phase = 4'h0;
    logic input_clock, crystal_drive_output, output_timing_clock, reset_output, bus_abort, fetch_start;
    logic nmi_pending, cpu_stall, strap_in, strap_out, strap_oe, strap_pullup_en, in_circuit_test_mode;
    logic pins_float, pd_pullup_en, pd_active;
    logic [19:0] fetch_address;
    logic [7:0] nmi_vector;
    int bad_count = 0, checks = 0;
    always #4 clock = ~clock;
    crs_top u_crs_top (.clock, .arst_n, .input_clock, .crystal_drive_output, .output_timing_clock,
        .reset_input_n, .reset_output, .bus_abort, .fetch_start, .fetch_address, .nmi_input, .nmi_ack,
        .nmi_pending, .nmi_vector, .test_busy_n, .wait_exec, .cpu_stall, .bus_phase, .bus_addr19,
        .bus_dma_cycle, .bus_refresh_cycle, .strap_in, .strap_out, .strap_oe, .strap_pullup_en,
        .in_circuit_test_mode, .pins_float, .powerdown_req, .powerdown_wake, .powerdown_delay_pin,
        .pd_pullup_en, .pd_active);
    crs_board u_crs_board (.clock, .hold_low, .strap_out, .strap_oe, .strap_pullup_en, .input_clock,
        .strap_in);
    //////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask
    task automatic wait_level(input int sel, input logic lvl);
        int n;
        n = 0;
        while ((sel == 0 ? fetch_start : pd_active) !== lvl) begin
            tick(1);
            n++;
            if (n > 200) begin
                bad_count++;
                close_out();
            end
        end
    endtask
    //////////////////////////////////////////////////////////////////////////////
    task automatic do_reset(input logic strap_low);
        arst_n = 1'b0;
        reset_input_n = 1'b0;
        hold_low = strap_low;
        tick(10);
        arst_n = 1'b1;
        tick(4);
        check(reset_output, 1'b1);
        check(bus_abort, 1'b1);
        check(strap_pullup_en, 1'b1);
        check(output_timing_clock, 1'b0);
        check(pd_pullup_en, 1'b0);
        reset_input_n = 1'b1;
        tick(4);
        hold_low = 1'b0;
        wait_level(0, 1'b1);
        check(output_timing_clock, 1'b1);
        check(fetch_address, CRS_FETCH_ADDR);
        check(reset_output, 1'b0);
        check(pd_pullup_en, 1'b1);
        check(in_circuit_test_mode, strap_low);
        check(pins_float, strap_low);
    endtask
    task automatic divider();
        int falls, toggles, highs;
        logic ic, oc;
        falls = 0;
        toggles = 0;
        highs = 0;
        ic = input_clock;
        oc = output_timing_clock;
        repeat (200) begin
            tick(1);
            falls += (ic && !input_clock);
            toggles += (oc != output_timing_clock);
            highs += output_timing_clock;
            ic = input_clock;
            oc = output_timing_clock;
        end
        check(falls - toggles <= 1 && toggles - falls <= 1, 1'b1);
        check(highs >= 90 && highs <= 110, 1'b1);
    endtask
    task automatic nmi_and_stall();
        nmi_input = 1'b1;
        tick(2);
        check(nmi_pending, 1'b0);
        tick(1);
        check(nmi_pending, 1'b1);
        check(nmi_vector, CRS_NMI_VECTOR);
        nmi_input = 1'b0;
        nmi_ack = 1'b1;
        tick(1);
        nmi_ack = 1'b0;
        check(nmi_pending, 1'b0);
        wait_exec = 1'b1;
        tick(3);
        check(cpu_stall, 1'b1);
        test_busy_n = 1'b0;
        tick(3);
        check(cpu_stall, 1'b0);
        wait_exec = 1'b0;
        nmi_input = 1'b1;
        tick(2);
        nmi_ack = 1'b1;
        tick(1);
        nmi_ack = 1'b0;
        check(nmi_pending, 1'b1);
        nmi_input = 1'b0;
        nmi_ack = 1'b1;
        tick(1);
        nmi_ack = 1'b0;
        check(nmi_pending, 1'b0);
    endtask
    task automatic strap_bus(input logic oe_exp);
        logic [3:0] ph[6] = '{4'h1, 4'h1, 4'h2, 4'h4, 4'h2, 4'h8};
        logic [5:0] a19 = 6'b010101, dma = 6'b001100, rfr = 6'b010000, out = 6'b011101;
        for (int i = 0; i < 6; i++) begin
            bus_phase = ph[i];
            bus_addr19 = a19[i];
            bus_dma_cycle = dma[i];
            bus_refresh_cycle = rfr[i];
            tick(1);
            check(strap_oe, oe_exp && i < 5);
            if (oe_exp && i < 5) check(strap_out, out[i]);
        end
        bus_phase = 4'h0;
    endtask
    task automatic powerdown();
        logic oc;
        powerdown_req = 1'b1;
        tick(1);
        powerdown_req = 1'b0;
        tick(1);
        check(pd_active, 1'b1);
        oc = output_timing_clock;
        tick(20);
        check(output_timing_clock, oc);
        check(crystal_drive_output, 1'b0);
        powerdown_wake = 1'b1;
        tick(1);
        powerdown_wake = 1'b0;
        tick(6);
        check(pd_active, 1'b1);
        powerdown_delay_pin = 1'b1;
        wait_level(1, 1'b0);
        powerdown_delay_pin = 1'b0;
        reset_input_n = 1'b0;
        tick(4);
        check(bus_abort, 1'b1);
        check(reset_output, 1'b1);
    endtask
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(1'b0);
        divider();
        nmi_and_stall();
        strap_bus(1'b1);
        powerdown();
        do_reset(1'b1);
        strap_bus(1'b0);
        close_out();
    end
endmodule
